// File: logic/nri_pkg.sv
// package: constants and types for the read-identifier responder
package nri_pkg;
    // ==========================================================
    // commands and addresses
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_SYNC_RESET = 8'hFC;
    localparam logic [7:0] ADDR_MAKER = 8'h00;
    localparam logic [7:0] ADDR_SIGNATURE = 8'h20;
    // ==========================================================
    // identifier bytes
    localparam logic [7:0] ID_MAKER_DEFAULT = 8'hA5; // arbitrary value
    localparam logic [7:0] ID_DEVICE_DEFAULT = 8'h5A; // arbitrary value
    localparam logic [1:0] LUN_ONE = 2'h0;
    localparam logic [1:0] CELL_SLC = 2'h0;
    localparam logic [3:0] BYTE2_RSVD = 4'h0;
    localparam logic [1:0] PAGE_4K = 2'h2;
    localparam logic [1:0] SPARE_28 = 2'h1;
    localparam logic [2:0] PAGES_128 = 3'h2;
    localparam logic [1:0] PLANES_TWO = 2'h1;
    localparam logic [2:0] BLOCKS_2048 = 3'h1;
    localparam logic [2:0] ASYNC_MODE4 = 3'h4;
    localparam logic [7:0] SIG_0 = 8'h4F;
    localparam logic [7:0] SIG_1 = 8'h4E;
    localparam logic [7:0] SIG_2 = 8'h46;
    localparam logic [7:0] SIG_3 = 8'h49;
    localparam logic [7:0] SIG_BEYOND = 8'h00;
    localparam int LEN_MAKER = 5;
    localparam int LEN_SIGNATURE = 4;
    // ==========================================================
    // buffering and reset values
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] IDX_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_ADDR,
        ST_READ_ID
    } nri_state_t;
endpackage : nri_pkg

// File: logic/nri_fifo_if.sv
// interface: byte stream between responder core and fifo
`timescale 1ns/10ps
interface nri_fifo_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : nri_fifo_if

// File: logic/nri_fifo.sv
// module: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module nri_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // sync reset, high
    input wire logic flush, // drop contents
    nri_fifo_if.snk in_if, // fill side
    input wire logic out_ready, // drain side ready
    output logic out_valid, // drain side valid
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    wire push = in_if.valid && in_if.ready;
    wire pop = out_valid && out_ready;
    wire [AW:0] depth_c = (AW+1)'(DEPTH);

    assign in_if.ready = (cnt_r != depth_c);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_if.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= AW'(wr_r + 1'b1);
            end
            if (pop) begin
                rd_r <= AW'(rd_r + 1'b1);
            end
            cnt_r <= (AW+1)'(cnt_r + push - pop);
        end
    end
endmodule : nri_fifo

// File: logic/nri_responder.sv
// module: read-identifier responder of a nand target
//
// Operation
// - accept read-identifier only while all logical units are idle
// - identifier mode persists until another valid command arrives
// - address 00h gives five bytes: maker, device, three config bytes
// - address 20h gives signature 4Fh 4Eh 46h 49h in order
// - asynchronous: each read-enable falling edge presents the next byte
// - synchronous: new byte per rising strobe, repeated on falling
// - third byte: one unit, single-level cell, upper bits zero, 00h
// - fourth byte: 4kB page, 28 spare, 128 pages, multi-unit bit
// - fifth byte: two planes, 2048 blocks, async mode 4; 85h
// - maker code first, device code second in five-byte sequence
`timescale 1ns/10ps
module nri_responder
    import nri_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = ID_MAKER_DEFAULT, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = ID_DEVICE_DEFAULT // arbitrary value
) (
    input wire logic ref_clk, // system clock 100 MHz
    input wire logic rst, // sync reset, high
    input wire logic cmd_valid, // command byte latched, one cycle
    input wire logic [7:0] cmd_byte, // command byte
    input wire logic cmd_known, // command byte is a valid command
    input wire logic addr_valid, // address byte latched, one cycle
    input wire logic [7:0] addr_byte, // address byte
    input wire logic luns_idle, // all logical units idle
    input wire logic multi_lun_en, // multi-unit support strap
    input wire logic sync_mode, // synchronous interface active
    input wire logic re_n_pin, // read enable pin, async
    input wire logic dqs_pin, // data strobe pin from host, sync
    input wire logic ale_pin, // address latch enable pin
    input wire logic cle_pin, // command latch enable pin
    output logic [7:0] dq_out, // data byte to pins
    output logic dq_oe, // drive enable for data pins
    output logic id_mode, // identifier-read mode active
    output logic fifo_full // byte buffer full
);
    // ==========================================================
    // pin synchronisers
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;

    always_ff @(posedge ref_clk) begin
        sync1_r <= {cle_pin, ale_pin, dqs_pin, re_n_pin};
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    wire re_n_s = sync2_r[0];
    wire dqs_s = sync2_r[1];
    wire ale_s = sync2_r[2];
    wire cle_s = sync2_r[3];

    // step on the read-enable fall so the byte is out while it is low
    wire re_fall = !re_n_s && sync3_r[0];
    wire dqs_rise = dqs_s && !sync3_r[1];
    wire ale_cle_hi = ale_s && cle_s;
    wire re_low = !re_n_s;

    // ==========================================================
    // command decode
    nri_state_t state_r;
    nri_state_t state_nxt;
    logic sig_sel_r;
    logic sig_sel_nxt;
    logic [2:0] idx_r;

    wire is_read_id = cmd_valid && (cmd_byte == CMD_READ_ID);
    wire read_id_ok = is_read_id && luns_idle;
    wire other_cmd = cmd_valid && cmd_known && !is_read_id;
    wire addr_maker = addr_valid && (addr_byte == ADDR_MAKER);
    wire addr_sig = addr_valid && (addr_byte == ADDR_SIGNATURE);

    always_comb begin
        state_nxt = state_r;
        sig_sel_nxt = sig_sel_r;
        case (state_r)
            ST_IDLE: begin
                if (read_id_ok) begin
                    state_nxt = ST_WAIT_ADDR;
                end
            end
            ST_WAIT_ADDR: begin
                if (other_cmd) begin
                    state_nxt = ST_IDLE;
                end else if (addr_maker || addr_sig) begin
                    state_nxt = ST_READ_ID;
                    sig_sel_nxt = addr_sig;
                end
            end
            ST_READ_ID: begin
                if (other_cmd) begin
                    state_nxt = ST_IDLE;
                end else if (read_id_ok) begin
                    state_nxt = ST_WAIT_ADDR;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // any entry, exit or re-arm of read mode flushes the buffer
    wire restart = (state_nxt != ST_READ_ID) || (state_r != ST_READ_ID);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            sig_sel_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sig_sel_r <= sig_sel_nxt;
        end
    end

    // ==========================================================
    // identifier byte table
    wire [7:0] byte2 = {BYTE2_RSVD, CELL_SLC, LUN_ONE};
    wire [7:0] byte3 = {multi_lun_en, PAGES_128, SPARE_28, PAGE_4K};
    wire [7:0] byte4 = {ASYNC_MODE4, BLOCKS_2048, PLANES_TWO};
    logic [7:0] id_byte;

    always_comb begin
        id_byte = SIG_BEYOND;
        if (sig_sel_r) begin
            case (idx_r)
                3'h0: id_byte = SIG_0;
                3'h1: id_byte = SIG_1;
                3'h2: id_byte = SIG_2;
                3'h3: id_byte = SIG_3;
                default: id_byte = SIG_BEYOND;
            endcase
        end else begin
            case (idx_r)
                3'h0: id_byte = MAKER_CODE;
                3'h1: id_byte = DEVICE_CODE;
                3'h2: id_byte = byte2;
                3'h3: id_byte = byte3;
                3'h4: id_byte = byte4;
                default: id_byte = SIG_BEYOND;
            endcase
        end
    end

    // ==========================================================
    // producer: fills the buffer in sequence order
    nri_fifo_if fif ();
    wire [2:0] seq_len = sig_sel_r ? 3'(LEN_SIGNATURE) : 3'(LEN_MAKER);
    logic more_r;

    assign fif.data = id_byte;
    assign fif.valid = (state_r == ST_READ_ID) && more_r && !restart;

    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            idx_r <= IDX_RESET;
            more_r <= 1'b1;
        end else if (fif.valid && fif.ready) begin
            idx_r <= 3'(idx_r + 1'b1);
            more_r <= (3'(idx_r + 1'b1) != seq_len);
        end
    end

    // ==========================================================
    // drain: strobe edges pull bytes from the buffer
    logic out_valid;
    logic [7:0] out_data;
    wire async_step = !sync_mode && re_fall;
    wire sync_step = sync_mode && ale_cle_hi && dqs_rise;
    wire take = async_step || sync_step;

    nri_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .flush(restart),
        .in_if(fif.snk),
        .out_ready(take),
        .out_valid(out_valid),
        .out_data(out_data)
    );

    logic [7:0] dq_r;
    logic oe_r;
    wire in_read = (state_r == ST_READ_ID);
    wire [7:0] dq_nxt = out_valid ? out_data : SIG_BEYOND;
    wire drive_async = !sync_mode && re_low;
    wire drive_sync = sync_mode && ale_cle_hi;
    wire oe_nxt = in_read && (drive_async || drive_sync);

    // ==========================================================
    // pin drivers: byte steps only on a take
    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            dq_r <= BYTE_RESET;
        end else if (take) begin
            dq_r <= dq_nxt;
        end
        // falling data-strobe edge keeps dq_r unchanged
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= oe_nxt;
        end
    end

    assign dq_out = dq_r;
    assign dq_oe = oe_r;
    assign id_mode = (state_r != ST_IDLE);
    assign fifo_full = !fif.ready;
endmodule : nri_responder

// File: testbench/nri_host_model.sv
// partner: host controller strobing identifier bytes out
`timescale 1ns/10ps
module nri_host_model (
    input wire logic ref_clk, // bench clock
    output logic re_n_pin = 1'b1, // read enable, idle high
    output logic dqs_pin = 1'b0, // data strobe, idle low
    output logic ale_pin = 1'b0, // address latch enable
    output logic cle_pin = 1'b0, // command latch enable
    output logic taken = 1'b0 // byte ready to compare
);
    // ==========================================================
    // one half period: let the byte land, then flag it
    task automatic half();
        repeat (6) @(negedge ref_clk);
        taken = 1'b1;
        @(negedge ref_clk);
        taken = 1'b0;
        @(negedge ref_clk);
    endtask : half
    // ==========================================================
    // one strobe cycle, 160 ns period, still between frames
    task automatic strobe(input logic sync);
        if (sync && !ale_pin) begin
            ale_pin = 1'b1;
            cle_pin = 1'b1;
            repeat (4) @(negedge ref_clk);
        end
        if (sync) dqs_pin = 1'b1;
        else re_n_pin = 1'b0;
        half();
        if (sync) dqs_pin = 1'b0;
        else re_n_pin = 1'b1;
        half();
    endtask : strobe
    // ==========================================================
    // close a synchronous frame
    task automatic end_frame();
        ale_pin = 1'b0;
        cle_pin = 1'b0;
        @(negedge ref_clk);
    endtask : end_frame
endmodule : nri_host_model

// File: testbench/nri_responder_properties.sv
// checker: concurrent properties of the read-identifier responder
`timescale 1ns/10ps
module nri_responder_properties
    import nri_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_known,
    input wire logic addr_valid,
    input wire logic [7:0] addr_byte,
    input wire logic luns_idle,
    input wire logic multi_lun_en,
    input wire logic sync_mode,
    input wire logic re_n_pin,
    input wire logic dqs_pin,
    input wire logic ale_pin,
    input wire logic cle_pin,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic id_mode,
    input wire logic fifo_full
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // named sequences
    sequence quiet;
        ($stable(re_n_pin) && $stable(dqs_pin) && !cmd_valid
            && !addr_valid) [*5];
    endsequence
    sequence re_low;
        (!sync_mode && !re_n_pin) [*5];
    endsequence
    sequence re_high;
        (!sync_mode && re_n_pin) [*5];
    endsequence
    // ==========================================================
    // properties
    a_busy_refused: assert property (cmd_valid && cmd_byte == CMD_READ_ID
        && !luns_idle && !id_mode |=> !id_mode) else $error("busy taken");
    a_cmd_enters: assert property (cmd_valid && cmd_byte == CMD_READ_ID
        && luns_idle |=> id_mode) else $error("read id not taken");
    a_mode_holds: assert property (id_mode
        && !(cmd_valid && cmd_known) |=> id_mode) else $error("mode lost");
    a_known_leaves: assert property (id_mode && cmd_valid && cmd_known
        && cmd_byte != CMD_READ_ID |=> !id_mode) else $error("mode kept");
    a_out_quiet: assert property (quiet |=> $stable(dq_out))
        else $error("data moved without strobe");
    a_fall_repeats: assert property (sync_mode && $fell(dqs_pin)
        |-> $stable(dq_out) [*6]) else $error("falling strobe moved data");
    a_oe_on: assert property (re_low |-> dq_oe)
        else $error("data not driven");
    a_oe_off: assert property (re_high |-> !dq_oe)
        else $error("data driven while idle");
endmodule : nri_responder_properties

bind nri_responder nri_responder_properties u_props (.ref_clk, .rst,
    .cmd_valid, .cmd_byte, .cmd_known, .addr_valid, .addr_byte, .luns_idle,
    .multi_lun_en, .sync_mode, .re_n_pin, .dqs_pin, .ale_pin, .cle_pin,
    .dq_out, .dq_oe, .id_mode, .fifo_full);

// File: testbench/tb_top.sv
// testbench: read-identifier responder against a host model
`timescale 1ns/10ps
module tb_top;
    import nri_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_known = 1'b0;
    logic addr_valid = 1'b0;
    logic luns_idle = 1'b1;
    logic multi_lun_en = 1'b0;
    logic sync_mode = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [7:0] addr_byte = 8'h00;
    logic re_n_pin, dqs_pin, ale_pin, cle_pin, taken;
    logic [7:0] dq_out;
    logic dq_oe, id_mode, fifo_full;
    logic [7:0] expq [$];
    logic [7:0] sig [4] = '{8'h4F, 8'h4E, 8'h46, 8'h49};
    logic [31:0] seed = 32'h0001_3566;
    int num_errors = 0;
    int comparisons = 0;

    always #5 ref_clk = ~ref_clk;

    nri_responder uut (.ref_clk, .rst, .cmd_valid, .cmd_byte, .cmd_known,
        .addr_valid, .addr_byte, .luns_idle, .multi_lun_en, .sync_mode,
        .re_n_pin, .dqs_pin, .ale_pin, .cle_pin, .dq_out, .dq_oe, .id_mode,
        .fifo_full);
    nri_host_model host (.ref_clk, .re_n_pin, .dqs_pin, .ale_pin, .cle_pin,
        .taken);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic put(input logic is_adr, input logic [7:0] b,
        input logic k);
        @(negedge ref_clk);
        cmd_valid = !is_adr;
        addr_valid = is_adr;
        cmd_byte = b;
        addr_byte = b;
        cmd_known = k;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        addr_valid = 1'b0;
        @(negedge ref_clk);
    endtask : put

    // ==========================================================
    // command, one address, then read the defined bytes only
    task automatic run(input logic [7:0] adr, input logic sm);
        logic [7:0] ids [5];
        int n;
        ids = '{ID_MAKER_DEFAULT, ID_DEVICE_DEFAULT, 8'h00,
            {multi_lun_en, 7'h26}, 8'h85};
        n = (adr == ADDR_SIGNATURE) ? 4 : 5;
        sync_mode = sm;
        put(1'b0, CMD_READ_ID, 1'b1);
        put(1'b1, adr, 1'b0);
        repeat (8) @(negedge ref_clk);
        chk("fifo_full", {7'h00, fifo_full}, 8'h00);
        for (int i = 0; i < n; i++) begin
            expq.push_back((n == 4) ? sig[i] : ids[i]);
            // byte must stand through both halves of the strobe
            expq.push_back(expq[$]);
            host.strobe(sm);
        end
        host.end_frame();
        for (int t = 0; t < 50 && expq.size() != 0; t++) @(negedge ref_clk);
        if (expq.size() != 0) begin
            num_errors++;
            test_done();
        end else begin
            $display("test address %h sync %b done", adr, sm);
        end
    endtask : run

    always @(posedge taken) begin
        if (expq.size() == 0) chk("queue", 8'h01, 8'h00);
        else chk("dq_out", dq_out, expq.pop_front());
    end

    initial begin
        #1000000;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        luns_idle = 1'b0;
        put(1'b0, CMD_READ_ID, 1'b1);
        chk("id_mode", {7'h00, id_mode}, 8'h00);
        luns_idle = 1'b1;
        $display("test busy refusal done");
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            multi_lun_en = seed[0] ^ k[0];
            run(ADDR_MAKER, 1'b0);
        end
        seed = lfsr(seed);
        put(1'b0, seed[15:8], 1'b0);
        chk("id_mode", {7'h00, id_mode}, 8'h01);
        run(ADDR_SIGNATURE, 1'b0);
        run(ADDR_SIGNATURE, 1'b1);
        run(ADDR_MAKER, 1'b1);
        rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        chk("dq_out", dq_out, BYTE_RESET);
        chk("dq_oe", {7'h00, dq_oe}, 8'h00);
        chk("id_mode", {7'h00, id_mode}, 8'h00);
        $display("test mid-run reset done");
        put(1'b0, CMD_READ_ID, 1'b1);
        chk("id_mode", {7'h00, id_mode}, 8'h01);
        put(1'b0, CMD_RESET, 1'b1);
        chk("id_mode", {7'h00, id_mode}, 8'h00);
        $display("test mode exit done");
        test_done();
    end
endmodule : tb_top
